/* File: hlfr_defines.vh */
// Constants for the holdover / free-run / loss-of-reference register slice.
// Assumes a single 100 MHz clock and the serial two-wire register port.
//
// Contract
// R1 - Sample holdover code until two equal samples
// R2 - High byte read returns 9:8, latches 7:0
// R3 - Low holdover register returns latched low byte
// R4 - Free-run code drives loop filter; high bits
// R5 - Low free-run byte writable, resets to FF
// R6 - Converter bit 1 drives holdover ADC disable
// R7 - Converter bit 0 drives free-run DAC disable
// R8 - Bits 6:4 add clocks before missing sync
// R9 - Bits 2:0 give line periods before reference loss
// R10 - Software should set reference wait to six
// R11 - Bits 4:0 give line periods before lock loss
// R12 - Software should set lock wait above six
// R13 - Upper holdover register returns snapshot bits 9:8
// R14 - Line sync restarts counters, clears indications; code does not restart unlock_ff or clear lock loss
`ifndef HLFR_DEFINES_VH
`define HLFR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define HLFR_OFS_HOLD_HIGH 8'h16
`define HLFR_OFS_HOLD_LOW 8'h17
`define HLFR_OFS_FREE_HIGH 8'h18
`define HLFR_OFS_FREE_LOW 8'h19
`define HLFR_OFS_CONV_DIS 8'h1A
`define HLFR_OFS_REF_THR 8'h1B
`define HLFR_OFS_LOCK_THR 8'h1C

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define HLFR_RST_FREE_HIGH 2'h1
`define HLFR_RST_FREE_LOW 8'hFF
`define HLFR_RST_ADC_DIS 1'h0
`define HLFR_RST_DAC_DIS 1'h0
`define HLFR_RST_MISS_EXTRA 3'h0
`define HLFR_RST_REF_WAIT 3'h1
`define HLFR_RST_LOCK_WAIT 5'h10

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define HLFR_ADC_DIS_BIT 1
`define HLFR_DAC_DIS_BIT 0
`define HLFR_MISS_EXTRA_MSB 6
`define HLFR_MISS_EXTRA_LSB 4
`define HLFR_REF_WAIT_MSB 2
`define HLFR_REF_WAIT_LSB 0
`define HLFR_LOCK_WAIT_MSB 4
`define HLFR_LOCK_WAIT_LSB 0

////////////////////////////////////////////////////////////////////////////////
// Timing
`define HLFR_CLK_PERIOD_NS 10
`define HLFR_LINE_TIME_NS 64000
`define HLFR_LINE_PERIOD_CLKS (`HLFR_LINE_TIME_NS / `HLFR_CLK_PERIOD_NS)

////////////////////////////////////////////////////////////////////////////////
// Serial port
`define HLFR_DEV_ADDR 7'h3A // Arbitrary bus address
`define HLFR_BYTE_BITS 4'h8

`endif

/* File: hlfr_sync_monitor.v */
// Line-sync watchdog: missing sync, loss of reference, first PLL lock loss.
// Assumes line_sync_pulse is a one-cycle pulse already in the clock domain.
`include "hlfr_defines.vh"

module hlfr_sync_monitor #(
  parameter LINE_PERIOD_CLKS = `HLFR_LINE_PERIOD_CLKS,
  parameter CNT_W = 16
) (
  input wire clock,
  input wire nrst,
  input wire line_sync_pulse,
  input wire pll1_unlocked,
  input wire [2:0] missing_extra,
  input wire [2:0] reference_loss_wait,
  input wire [4:0] first_pll_lock_loss_wait,
  output reg hsync_missing_ff,
  output reg loss_of_reference_ff,
  output reg lock_loss_ff
);

  reg [CNT_W-1:0] since_sync_ff;
  reg [CNT_W-1:0] period_ff;
  reg [2:0] missed_ff;
  reg [4:0] unlock_ff;
  wire line_tick;
  wire overdue;

  // Synthetic line tick stands in for each absent sync pulse
  assign line_tick = (period_ff == LINE_PERIOD_CLKS[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});
  assign overdue = since_sync_ff >= LINE_PERIOD_CLKS[CNT_W-1:0] + {{(CNT_W-3){1'b0}}, missing_extra}; // R8

  ////////////////////////////////////////////////////////////////////////////////
  // Counters except unlock_ff restart on every sync; all but period_ff saturate so they never wrap back to clean
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      since_sync_ff <= {CNT_W{1'b0}};
      period_ff <= {CNT_W{1'b0}};
      missed_ff <= 3'h0;
      unlock_ff <= 5'h0;
    end else begin
      if (line_sync_pulse) begin
        since_sync_ff <= {CNT_W{1'b0}}; // R14
        period_ff <= {CNT_W{1'b0}}; // R14
        missed_ff <= 3'h0; // R14
      end else begin
        if (!(&since_sync_ff))
          since_sync_ff <= since_sync_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        if (line_tick) begin
          period_ff <= {CNT_W{1'b0}};
          if (!(&missed_ff))
            missed_ff <= missed_ff + 3'h1; // R9
        end else begin
          period_ff <= period_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
      // Lock wait counts line periods, real or synthetic
      if (!pll1_unlocked)
        unlock_ff <= 5'h0;
      else if ((line_sync_pulse || line_tick) && !(&unlock_ff))
        unlock_ff <= unlock_ff + 5'h1; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Indications, all registered
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hsync_missing_ff <= 1'b0;
      loss_of_reference_ff <= 1'b0;
      lock_loss_ff <= 1'b0;
    end else begin
      hsync_missing_ff <= overdue && !line_sync_pulse; // R8 R14
      loss_of_reference_ff <= (missed_ff >= reference_loss_wait) && (missed_ff != 3'h0) && !line_sync_pulse; // R9 R14
      lock_loss_ff <= pll1_unlocked && (unlock_ff >= first_pll_lock_loss_wait); // R11
    end
  end

endmodule

/* File: hlfr_regs.v */
// Holdover / free-run register slice behind the two-wire serial register port.
// Assumes scl and sda arrive from pins; the bench resolves sda from sda_oe.
// Holdover code comes from the converter, asynchronous to this clock.
// Outputs are registered; sda_out stays low and sda_oe does the pulling.
`include "hlfr_defines.vh"

module hlfr_regs #(
  parameter [6:0] DEV_ADDR = `HLFR_DEV_ADDR,
  parameter LINE_PERIOD_CLKS = `HLFR_LINE_PERIOD_CLKS,
  parameter CODE_W = 10
) (
  input wire clock,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire [CODE_W-1:0] holdover_converter_code,
  input wire line_sync,
  input wire pll1_unlocked,
  output reg [CODE_W-1:0] freerun_voltage_code,
  output reg adc_disable,
  output reg dac_disable,
  output wire hsync_missing,
  output wire loss_of_reference,
  output wire pll1_lock_loss
);

  // One-hot serial port states
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_DEV = 9'h002;
  localparam [8:0] ST_DACK = 9'h004;
  localparam [8:0] ST_PTR = 9'h008;
  localparam [8:0] ST_PACK = 9'h010;
  localparam [8:0] ST_WR = 9'h020;
  localparam [8:0] ST_WACK = 9'h040;
  localparam [8:0] ST_RD = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only the second stages
  // Reset levels match idle pins, so no false edge follows reset
  reg scl_m_ff;
  reg scl_s_ff;
  reg scl_d_ff;
  reg sda_m_ff;
  reg sda_s_ff;
  reg sda_d_ff;
  reg sync_m_ff;
  reg sync_s_ff;
  reg sync_d_ff;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      scl_d_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
      sda_d_ff <= 1'b1;
      sync_m_ff <= 1'b0;
      sync_s_ff <= 1'b0;
      sync_d_ff <= 1'b0;
    end else begin
      scl_m_ff <= scl;
      scl_s_ff <= scl_m_ff;
      scl_d_ff <= scl_s_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
      sda_d_ff <= sda_s_ff;
      sync_m_ff <= line_sync;
      sync_s_ff <= sync_m_ff;
      sync_d_ff <= sync_s_ff;
    end
  end

  // Edges from the second and third stages; start and stop need scl high on both
  wire scl_rise = scl_s_ff && !scl_d_ff;
  wire scl_fall = !scl_s_ff && scl_d_ff;
  wire start_seen = scl_s_ff && scl_d_ff && !sda_s_ff && sda_d_ff;
  wire stop_seen = scl_s_ff && scl_d_ff && sda_s_ff && !sda_d_ff;
  wire line_sync_pulse = sync_s_ff && !sync_d_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Holdover code capture: equal consecutive samples make the snapshot
  reg [CODE_W-1:0] code_m_ff;
  reg [CODE_W-1:0] code_s_ff;
  reg [CODE_W-1:0] code_d_ff;
  reg [CODE_W-1:0] snapshot_ff;

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      code_m_ff <= {CODE_W{1'b0}};
      code_s_ff <= {CODE_W{1'b0}};
      code_d_ff <= {CODE_W{1'b0}};
      snapshot_ff <= {CODE_W{1'b0}};
    end else begin
      code_m_ff <= holdover_converter_code;
      code_s_ff <= code_m_ff;
      code_d_ff <= code_s_ff;
      // A code caught mid-transition never matches its neighbour
      // Limitation: a code that never settles keeps the older snapshot
      if (code_s_ff == code_d_ff)
        snapshot_ff <= code_d_ff; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  reg [7:0] hold_low_latch_ff;
  reg [2:0] miss_extra_ff;
  reg [2:0] ref_wait_ff;
  reg [4:0] lock_wait_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port engine state, declared ahead of the read mux that uses the pointer
  reg [8:0] state_ff;
  reg [7:0] ptr_ff;
  reg [7:0] shift_ff;
  reg [3:0] bits_ff;
  reg read_ff;
  reg wr_en;
  reg load_rd;

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits read as zero
  // Low holdover byte reads zero until the first high-byte read
  reg [7:0] rdata;
  always @* begin
    case (ptr_ff)
      `HLFR_OFS_HOLD_HIGH: rdata = {6'h00, snapshot_ff[CODE_W-1:CODE_W-2]}; // R13
      `HLFR_OFS_HOLD_LOW: rdata = hold_low_latch_ff; // R3
      `HLFR_OFS_FREE_HIGH: rdata = {6'h00, freerun_voltage_code[CODE_W-1:CODE_W-2]};
      `HLFR_OFS_FREE_LOW: rdata = freerun_voltage_code[7:0];
      `HLFR_OFS_CONV_DIS: rdata = {6'h00, adc_disable, dac_disable};
      `HLFR_OFS_REF_THR: rdata = {1'b0, miss_extra_ff, 1'b0, ref_wait_ff};
      `HLFR_OFS_LOCK_THR: rdata = {3'h0, lock_wait_ff};
      default: rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port engine; the pointer auto-increments after every data byte
  // Ack is driven from the scl fall that ends the eighth bit

  // Byte write strobe and read-load strobe, decoded on scl falling edges
  always @* begin
    wr_en = 1'b0;
    load_rd = 1'b0;
    if (scl_fall && !start_seen && !stop_seen) begin
      case (state_ff)
        ST_WR: wr_en = (bits_ff == `HLFR_BYTE_BITS);
        ST_DACK: load_rd = read_ff;
        ST_RACK: load_rd = 1'b1;
        default: begin
          wr_en = 1'b0;
          load_rd = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      ptr_ff <= 8'h00;
      shift_ff <= 8'h00;
      bits_ff <= 4'h0;
      read_ff <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps the pointer for a following read
      state_ff <= ST_DEV;
      bits_ff <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state_ff <= ST_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      case (state_ff)
        ST_DEV, ST_PTR, ST_WR: begin
          shift_ff <= {shift_ff[6:0], sda_s_ff};
          bits_ff <= bits_ff + 4'h1;
        end
        ST_RD: bits_ff <= bits_ff + 4'h1;
        // Master not-acknowledge ends the read burst
        ST_RACK: if (sda_s_ff) state_ff <= ST_IDLE;
        default: state_ff <= state_ff;
      endcase
    end else if (scl_fall) begin
      case (state_ff)
        ST_DEV: begin
          if (bits_ff == `HLFR_BYTE_BITS) begin
            if (shift_ff[7:1] == DEV_ADDR) begin
              state_ff <= ST_DACK;
              read_ff <= shift_ff[0];
              sda_oe <= 1'b1;
            end else begin
              // Foreign address: stay off the line until the next start
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_DACK, ST_RACK: begin
          bits_ff <= 4'h0;
          // First read bit comes from the mux at this fall
          if (read_ff) begin
            state_ff <= ST_RD;
            shift_ff <= {rdata[6:0], 1'b0};
            sda_oe <= !rdata[7];
            ptr_ff <= ptr_ff + 8'h01;
          end else begin
            state_ff <= ST_PTR;
            sda_oe <= 1'b0;
          end
        end
        ST_PTR: begin
          if (bits_ff == `HLFR_BYTE_BITS) begin
            ptr_ff <= shift_ff;
            state_ff <= ST_PACK;
            sda_oe <= 1'b1;
          end
        end
        ST_PACK, ST_WACK: begin
          state_ff <= ST_WR;
          bits_ff <= 4'h0;
          sda_oe <= 1'b0;
        end
        ST_WR: begin
          if (bits_ff == `HLFR_BYTE_BITS) begin
            state_ff <= ST_WACK;
            ptr_ff <= ptr_ff + 8'h01;
            sda_oe <= 1'b1;
          end
        end
        ST_RD: begin
          if (bits_ff == `HLFR_BYTE_BITS) begin
            state_ff <= ST_RACK;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= !shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Writable registers and the coherent low-byte latch
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      freerun_voltage_code <= {`HLFR_RST_FREE_HIGH, `HLFR_RST_FREE_LOW}; // R4 R5
      adc_disable <= `HLFR_RST_ADC_DIS;
      dac_disable <= `HLFR_RST_DAC_DIS;
      miss_extra_ff <= `HLFR_RST_MISS_EXTRA;
      ref_wait_ff <= `HLFR_RST_REF_WAIT;
      lock_wait_ff <= `HLFR_RST_LOCK_WAIT;
      hold_low_latch_ff <= 8'h00;
    end else begin
      // Low byte frozen at the high-byte read so both halves match
      if (load_rd && ptr_ff == `HLFR_OFS_HOLD_HIGH)
        hold_low_latch_ff <= snapshot_ff[7:0]; // R2
      // Reserved bits dropped; read-only and unmapped offsets acked and ignored
      if (wr_en) begin
        case (ptr_ff)
          `HLFR_OFS_FREE_HIGH: freerun_voltage_code[CODE_W-1:CODE_W-2] <= shift_ff[1:0]; // R4
          `HLFR_OFS_FREE_LOW: freerun_voltage_code[7:0] <= shift_ff; // R5
          `HLFR_OFS_CONV_DIS: begin
            adc_disable <= shift_ff[`HLFR_ADC_DIS_BIT]; // R6
            dac_disable <= shift_ff[`HLFR_DAC_DIS_BIT]; // R7
          end
          `HLFR_OFS_REF_THR: begin
            miss_extra_ff <= shift_ff[`HLFR_MISS_EXTRA_MSB:`HLFR_MISS_EXTRA_LSB]; // R8
            ref_wait_ff <= shift_ff[`HLFR_REF_WAIT_MSB:`HLFR_REF_WAIT_LSB]; // R9
          end
          `HLFR_OFS_LOCK_THR: lock_wait_ff <= shift_ff[`HLFR_LOCK_WAIT_MSB:`HLFR_LOCK_WAIT_LSB]; // R11
          default: lock_wait_ff <= lock_wait_ff;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line-sync watchdog; its outputs are its own flip-flops
  // Threshold writes take effect at once, even mid-count
  hlfr_sync_monitor #(
    .LINE_PERIOD_CLKS(LINE_PERIOD_CLKS)
  ) hlfr_sync_monitor_inst (
    .clock(clock),
    .nrst(nrst),
    .line_sync_pulse(line_sync_pulse),
    .pll1_unlocked(pll1_unlocked),
    .missing_extra(miss_extra_ff),
    .reference_loss_wait(ref_wait_ff),
    .first_pll_lock_loss_wait(lock_wait_ff),
    .hsync_missing_ff(hsync_missing),
    .loss_of_reference_ff(loss_of_reference),
    .lock_loss_ff(pll1_lock_loss)
  );

endmodule

/* File: hlfr_regs_checker.sv */
// Port checker for the holdover / free-run register slice.
// Assumes it is bound onto hlfr_regs; one clock, async active-low reset.
module hlfr_regs_checker #(
  parameter LINE_PERIOD_CLKS = 20,
  parameter CODE_W = 10
) (
  input wire clock,
  input wire nrst,
  input wire scl,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire [CODE_W-1:0] holdover_converter_code,
  input wire line_sync,
  input wire pll1_unlocked,
  input wire [CODE_W-1:0] freerun_voltage_code,
  input wire adc_disable,
  input wire dac_disable,
  input wire hsync_missing,
  input wire loss_of_reference,
  input wire pll1_lock_loss
);
  timeunit 1ns;
  timeprecision 100ps;
  // Single domain, so one clocking and one disable for all
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  // Sync arrival, then the quiet stretch that must follow it
  sequence s_sync_edge;
    $rose(line_sync);
  endsequence
  sequence s_quiet_line;
    (!hsync_missing)[*8];
  endsequence
  ////////////////////////////////////////
  // Register writes and data-line pulls land only while the serial clock is low
  AST_FREE_WR: assert property ($changed(freerun_voltage_code) |-> !scl && !$past(scl))
    else $error("free-run code changed outside a write");
  AST_CONV_WR: assert property (($changed(adc_disable) || $changed(dac_disable)) |-> !scl)
    else $error("disable pins changed outside a write");
  AST_ACK_SCL_LOW: assert property ($rose(sda_oe) |-> !scl)
    else $error("data line pulled while serial clock high");
  // Sync clears the missing-sync and reference-loss indications and restarts the count
  AST_MISS_QUIET: assert property (s_sync_edge |-> ##6 s_quiet_line)
    else $error("missing sync flagged right after a sync");
  AST_REF_LOSS_CLEAR: assert property (s_sync_edge |-> ##[1:6] !loss_of_reference)
    else $error("reference loss not cleared by sync");
  AST_MISS_NEEDS_GAP: assert property ($rose(hsync_missing) |-> !line_sync && !$past(line_sync, 8))
    else $error("missing sync flagged while sync present");
  // Lock loss follows the unlocked input both ways
  AST_LOCK_CAUSE: assert property ($rose(pll1_lock_loss) |-> $past(pll1_unlocked))
    else $error("lock loss without unlocked input");
  AST_LOCK_CLEAR: assert property ($fell(pll1_unlocked) |-> ##[1:3] !pll1_lock_loss)
    else $error("lock loss not cleared on relock");
endmodule

bind hlfr_regs hlfr_regs_checker #(.LINE_PERIOD_CLKS(LINE_PERIOD_CLKS), .CODE_W(CODE_W)) hlfr_regs_checker_inst (
  .clock(clock), .nrst(nrst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .holdover_converter_code(holdover_converter_code), .line_sync(line_sync), .pll1_unlocked(pll1_unlocked),
  .freerun_voltage_code(freerun_voltage_code), .adc_disable(adc_disable), .dac_disable(dac_disable),
  .hsync_missing(hsync_missing), .loss_of_reference(loss_of_reference), .pll1_lock_loss(pll1_lock_loss));

/* File: tb_hlfr_regs.sv */
// Self-checking bench for the holdover / free-run register slice.
// Assumes a pulled-up data line and a shortened line period.
`include "hlfr_defines.vh"
module tb_hlfr_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LP = 20;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic line_sync = 1'b0;
  logic pll1_unlocked = 1'b0;
  logic [9:0] hold_code = 10'h000;
  logic [7:0] q0, q1;
  logic k;
  logic [7:0] cv [4] = '{8'h02, 8'h01, 8'hFF, 8'h00};
  logic [2:0] ev [2] = '{3'h0, 3'h7};
  int fails = 0;
  int cmp_count = 0;
  wire sda_out, sda_oe, adc_disable, dac_disable, hsync_missing, loss_of_reference, pll1_lock_loss;
  wire [9:0] free_code;
  // Open drain: device only pulls low
  wire sda = sda_oe ? 1'b0 : sda_m;
  ////////////////////////////////////////
  // Design with a short line period to keep the run brief
  hlfr_regs #(.LINE_PERIOD_CLKS(LP)) hlfr_regs_inst (
    .clock(clock), .nrst(nrst), .scl(scl_m), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .holdover_converter_code(hold_code), .line_sync(line_sync), .pll1_unlocked(pll1_unlocked),
    .freerun_voltage_code(free_code), .adc_disable(adc_disable), .dac_disable(dac_disable),
    .hsync_missing(hsync_missing), .loss_of_reference(loss_of_reference), .pll1_lock_loss(pll1_lock_loss));
  // 100 MHz clock
  always #5 clock = ~clock;
  ////////////////////////////////////////
  // Bus helpers; each phase holds 8 clocks, above the 4 needed
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic bus(input logic c, input logic d);
    scl_m = c;
    sda_m = d;
    tick(8);
  endtask
  // Data moves only after clock low, else it reads as start or stop
  task automatic bit_io(input logic b, output logic r);
    bus(1'b0, sda_m);
    bus(1'b0, b);
    bus(1'b1, b);
    r = sda;
  endtask
  // s = 0 gives start, s = 1 gives stop
  task automatic cond(input logic s);
    bus(1'b0, sda_m);
    bus(1'b0, !s);
    bus(1'b1, !s);
    bus(1'b1, s);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, n);
  endtask
  task automatic check(input logic [9:0] got, input logic [9:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic send(input logic [7:0] d);
    byte_io(d, 1'b1, q0, k);
    check({9'h000, k}, 10'h000, "no ack");
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] val);
    cond(1'b0);
    send({`HLFR_DEV_ADDR, 1'b0});
    send(ofs);
    send(val);
    cond(1'b1);
  endtask
  // Two-byte burst read into q0 and q1
  task automatic reg_rd(input logic [7:0] ofs);
    cond(1'b0);
    send({`HLFR_DEV_ADDR, 1'b0});
    send(ofs);
    cond(1'b0);
    send({`HLFR_DEV_ADDR, 1'b1});
    byte_io(8'hFF, 1'b0, q0, k);
    byte_io(8'hFF, 1'b1, q1, k);
    cond(1'b1);
  endtask
  task automatic pulse();
    line_sync = 1'b1;
    tick(3);
    line_sync = 1'b0;
    tick(8);
  endtask
  function automatic logic flag(input int w);
    return w == 0 ? hsync_missing : (w == 1 ? loss_of_reference : pll1_lock_loss);
  endfunction
  // Bounded wait; running out ends the run
  task automatic wait_flag(input int w, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (flag(w) !== lvl && n < hi) begin
      tick(1);
      n++;
    end
    cmp_count++;
    if (flag(w) !== lvl) begin
      fails++;
      $display("Error at %0t: flag %0d wait ran out", $time, w);
      finish_test();
    end else if (n < lo) begin
      fails++;
      $display("Error at %0t: flag %0d after %0d cycles", $time, w, n);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence
  initial begin
    tick(10);
    nrst = 1'b1;
    tick(3);
    check(free_code, 10'h1FF, "free code");
    check({8'h00, adc_disable, dac_disable}, 10'h000, "disables");
    check({9'h000, sda_out}, 10'h000, "sda_out");
    check({7'h00, hsync_missing, loss_of_reference, pll1_lock_loss}, 10'h000, "flags");
    // Foreign address must be left unanswered
    cond(1'b0);
    byte_io({`HLFR_DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q0, k);
    check({9'h000, k}, 10'h001, "foreign address acked");
    cond(1'b1);
    reg_rd(`HLFR_OFS_FREE_HIGH);
    check({2'h0, q0}, 10'h001, "free high");
    check({2'h0, q1}, 10'h0FF, "free low");
    reg_rd(`HLFR_OFS_CONV_DIS);
    check({2'h0, q0}, 10'h000, "conv");
    check({2'h0, q1}, 10'h001, "ref thr");
    reg_rd(`HLFR_OFS_LOCK_THR);
    check({2'h0, q0}, 10'h010, "lock thr");
    check({2'h0, q1}, 10'h000, "unmapped");
    $display("Test reset values done");
    reg_wr(`HLFR_OFS_FREE_HIGH, 8'hFE);
    reg_wr(`HLFR_OFS_FREE_LOW, 8'h5A);
    check(free_code, 10'h25A, "free code");
    reg_rd(`HLFR_OFS_FREE_HIGH);
    check({2'h0, q0}, 10'h002, "free high");
    check({2'h0, q1}, 10'h05A, "free low");
    foreach (cv[i]) begin
      reg_wr(`HLFR_OFS_CONV_DIS, cv[i]);
      check({8'h00, adc_disable, dac_disable}, {8'h00, cv[i][1:0]}, "disable pins");
      reg_rd(`HLFR_OFS_CONV_DIS);
      check({2'h0, q0}, {8'h00, cv[i][1:0]}, "conv read");
    end
    $display("Test control writes done");
    hold_code = 10'h2C3;
    tick(10);
    reg_rd(`HLFR_OFS_HOLD_HIGH);
    check({2'h0, q0}, 10'h002, "hold high");
    check({2'h0, q1}, 10'h0C3, "hold low");
    hold_code = 10'h15A;
    tick(10);
    reg_wr(`HLFR_OFS_HOLD_LOW, 8'h00);
    reg_rd(`HLFR_OFS_HOLD_LOW);
    check({2'h0, q0}, 10'h0C3, "latched low");
    reg_rd(`HLFR_OFS_HOLD_HIGH);
    check({2'h0, q0}, 10'h001, "hold high");
    check({2'h0, q1}, 10'h05A, "hold low");
    $display("Test holdover snapshot done");
    foreach (ev[i]) begin
      reg_wr(`HLFR_OFS_REF_THR, {1'b0, ev[i], 4'h2});
      pulse();
      check({8'h00, hsync_missing, loss_of_reference}, 10'h000, "cleared by sync");
      wait_flag(0, 1'b1, LP + ev[i] - 10, LP + ev[i] - 4);
      wait_flag(1, 1'b1, 1, 2 * LP + 10);
    end
    reg_wr(`HLFR_OFS_LOCK_THR, 8'h03);
    pll1_unlocked = 1'b1;
    pulse();
    wait_flag(2, 1'b1, 2 * LP - 11, 4 * LP + 10);
    pll1_unlocked = 1'b0;
    wait_flag(2, 1'b0, 0, 4);
    $display("Test sync monitor done");
    reg_wr(`HLFR_OFS_REF_THR, 8'h06);
    reg_wr(`HLFR_OFS_LOCK_THR, 8'h07);
    reg_rd(`HLFR_OFS_REF_THR);
    check({2'h0, q0}, 10'h006, "ref thr");
    check({2'h0, q1}, 10'h007, "lock thr");
    $display("Test threshold setup done");
    // Mid-run reset must bring back the defaults
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(3);
    check(free_code, 10'h1FF, "free code after reset");
    check({7'h00, hsync_missing, loss_of_reference, pll1_lock_loss}, 10'h000, "flags after reset");
    reg_rd(`HLFR_OFS_REF_THR);
    check({2'h0, q0}, 10'h001, "ref thr after reset");
    check({2'h0, q1}, 10'h010, "lock thr after reset");
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule
